// ===== shared/moch_cfg.svh
// Offsets, reset values, limits and timing counts of the command handler.
`ifndef MOCH_CFG_SVH
`define MOCH_CFG_SVH
`define MOCH_CLK_HZ        100000000
`define MOCH_CLK_NS        10
`define MOCH_TICK_NS       1000000
`define MOCH_TICK_CYC      (`MOCH_TICK_NS / `MOCH_CLK_NS)
`define MOCH_ADDR_SETTLE_MS 15000
`define MOCH_SPAN_WIN_MS   300000
`define MOCH_PROC_MAX_MS   10000
`define MOCH_PROC_MS       2000
`define MOCH_MINUTE_MS     60000
`define MOCH_LED_PERIOD_MS 2000
`define MOCH_LED_ON_MS     150
`define MOCH_LED_GAP_MS    300
`define MOCH_ZERO_TOL_DIV  50
`define MOCH_GLITCH_CYC    16
`define MOCH_BIT_CYC_0     (`MOCH_CLK_HZ / 9600)
`define MOCH_BIT_CYC_1     (`MOCH_CLK_HZ / 19200)
`define MOCH_BIT_CYC_2     (`MOCH_CLK_HZ / 38400)
`define MOCH_BIT_CYC_3     (`MOCH_CLK_HZ / 57600)
`define MOCH_BIT_CYC_4     (`MOCH_CLK_HZ / 76800)
`define MOCH_BIT_CYC_5     (`MOCH_CLK_HZ / 115200)
`define MOCH_ADDR_MAX      127
`define MOCH_OFS_CTRL      8'h00
`define MOCH_OFS_STAT      8'h04
`define MOCH_OFS_DEVID     8'h08
`define MOCH_OFS_NETCFG    8'h0C
`define MOCH_OFS_ZREF      8'h10
`define MOCH_OFS_SVC       8'h14
`define MOCH_OFS_PASS      8'h18
`define MOCH_OFS_OBJ       8'h1C
`define MOCH_RST_MAXMASTER 7'h7F
`define MOCH_RST_MAXINFO   8'h01
`define MOCH_RST_ZREF      16'h0FA0
`define MOCH_OBJ_COUNT     12
`endif

// ===== shared/moch_pkg.sv
// Types shared by the command handler.
package moch_pkg;
  typedef enum logic [1:0] {P_IDLE = 2'b00, P_RUN = 2'b01, P_FAIL = 2'b10, P_DONE = 2'b11} moch_proc_t;
  typedef enum logic [1:0] {REQ_OTHER = 2'b00, REQ_WHOIS = 2'b01, REQ_READPROP = 2'b10} moch_req_t;
  typedef enum logic [1:0] {OBJ_DEVICE = 2'b00, OBJ_AIN = 2'b01, OBJ_AVAL = 2'b10, OBJ_BVAL = 2'b11} moch_obj_t;
endpackage

// ===== verification/moch_handler_tb_top.sv
// Self-checking testbench for the command handler.
`timescale 1ns/1ps
`default_nettype none
`include "moch_cfg.svh"
module moch_handler_tb_top
  import moch_pkg::*;
;
  localparam int          TICK    = 10;
  localparam int          PROC    = 20;
  localparam logic [31:0] PASS_OK = 32'h1234ABCD; // Arbitrary value.
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  sw = 8'h05;
  logic [15:0] vel = 16'h0FA0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic [7:0]  active_addr;
  logic [2:0]  baud_sel;
  logic [1:0]  req_kind;
  logic        hreadyout, hresp, rx_pin, req_done, req_ok, led_red, baud_locked, addr_err;
  logic        comm_disabled, reinit_pulse, reinit_warm, cz, cs, cr;
  logic        led_on = 1'b0;
  int          n_mismatch = 0, n_tests = 0, cyc = 0, n_led = 0, n_z = 0, n_s = 0, n_r = 0, n_rst = 0;
  always #5 hclk = ~hclk;
  moch_handler #(.TICK_CYCLES(TICK), .PASSWORD(PASS_OK), .PROC_MS(PROC)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rx_pin(rx_pin), .station_address_switch(sw), .led_red(led_red),
    .req_done(req_done), .req_kind(req_kind), .req_ok(req_ok), .velocity_now(vel),
    .baud_sel(baud_sel), .baud_locked(baud_locked), .addr_err(addr_err), .active_addr(active_addr),
    .comm_disabled(comm_disabled), .reinit_pulse(reinit_pulse), .reinit_warm(reinit_warm),
    .cal_zero_pulse(cz), .cal_span_pulse(cs), .cal_restore_pulse(cr));
  moch_master_model u_master (
    .hclk(hclk), .rx_pin(rx_pin), .req_done(req_done), .req_kind(req_kind), .req_ok(req_ok));
  ////////////////////////////////////////
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    n_led <= n_led + int'(led_on && $rose(led_red));
    n_z <= n_z + int'(cz === 1'b1);
    n_s <= n_s + int'(cs === 1'b1);
    n_r <= n_r + int'(cr === 1'b1);
    n_rst <= n_rst + int'(reinit_pulse === 1'b1);
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Single word transfers; the master waits on hready and never assumes a latency.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(d & m, e);
  endtask
  task automatic svc(input logic [31:0] p, input logic [31:0] c);
    xfer(`MOCH_OFS_PASS, 1'b1, p);
    xfer(`MOCH_OFS_SVC, 1'b1, c);
    repeat (4) @(posedge hclk);
  endtask
  task automatic rst(input logic [7:0] s);
    hresetn <= 1'b0;
    sw <= s;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask
  ////////////////////////////////////////
  initial begin
    rst(8'h80);
    chk(32'(addr_err), 32'h1);
    rst(8'h05);
    chk(32'(addr_err), 32'h0);
    chk(32'(baud_locked), 32'h0);
    chk(32'({hresp, active_addr}), 32'h5);
    rdc(`MOCH_OFS_DEVID, 32'h003FFFFF, 32'h000186A5);
    led_on <= 1'b1;
    repeat (20000) @(posedge hclk);
    led_on <= 1'b0;
    chk(n_led, 32'h2);
    u_master.frame(8'h55);
    u_master.req(REQ_OTHER, 1'b1);
    repeat (4) @(posedge hclk);
    chk(32'(baud_locked), 32'h0);
    u_master.req(REQ_WHOIS, 1'b0);
    repeat (4) @(posedge hclk);
    chk(32'(baud_locked), 32'h0);
    for (int t = 0; t < 3 && baud_locked !== 1'b1; t++) u_master.req(REQ_READPROP, 1'b1);
    repeat (4) @(posedge hclk);
    chk(32'(baud_locked), 32'h1);
    chk(32'(baud_sel), 32'h5);
    xfer(`MOCH_OFS_DEVID, 1'b1, 32'h0002ABCD);
    rdc(`MOCH_OFS_DEVID, 32'h003FFFFF, 32'h0002ABCD);
    xfer(`MOCH_OFS_NETCFG, 1'b1, 32'h00000305);
    rdc(`MOCH_OFS_NETCFG, 32'hFFFFFFFF, 32'h017F0305);
    svc(32'h0, 32'h3);
    chk(n_rst, 32'h0);
    rdc(`MOCH_OFS_STAT, 32'h00080000, 32'h00080000);
    svc(PASS_OK, 32'h5);
    chk(n_rst, 32'h0);
    svc(PASS_OK, 32'h3);
    chk({reinit_warm, n_rst[30:0]}, 32'h80000001);
    rdc(`MOCH_OFS_NETCFG, 32'hFFFFFFFF, 32'h03050305);
    svc(PASS_OK, 32'h1);
    chk({reinit_warm, n_rst[30:0]}, 32'h00000002);
    svc(32'h0, 32'h0502);
    chk(32'(comm_disabled), 32'h0);
    svc(PASS_OK, 32'h0502);
    chk(32'(comm_disabled), 32'h1);
    rdc(`MOCH_OFS_SVC, 32'h000000FF, 32'h00000005);
    svc(PASS_OK, 32'h0);
    chk(32'(comm_disabled), 32'h0);
    for (int i = 0; i < 13; i++) begin
      xfer(`MOCH_OFS_OBJ, 1'b1, 32'(i));
      rdc(`MOCH_OFS_OBJ, 32'h00000F00, (i < 12) ? 32'(i << 8) : 32'h0);
      if (i < 12) chk(32'(d[7:6]), 32'((i + 3) / 4));
      if (i > 0 && i < 9) chk(32'(d[5]), 32'(i % 2 == 0));
    end
    xfer(`MOCH_OFS_CTRL, 1'b1, 32'h2);
    repeat (5) @(posedge hclk);
    rdc(`MOCH_OFS_CTRL, 32'h2, 32'h0);
    vel <= 16'h0FF1;
    xfer(`MOCH_OFS_CTRL, 1'b1, 32'h1);
    repeat (5) @(posedge hclk);
    rdc(`MOCH_OFS_CTRL, 32'h1, 32'h0);
    chk(n_z, 32'h0);
    vel <= 16'h0FF0;
    xfer(`MOCH_OFS_CTRL, 1'b1, 32'h1);
    rdc(`MOCH_OFS_CTRL, 32'h1, 32'h1);
    repeat ((PROC + 2) * TICK) @(posedge hclk);
    rdc(`MOCH_OFS_CTRL, 32'h1, 32'h1);
    chk(n_z, 32'h1);
    xfer(`MOCH_OFS_CTRL, 1'b1, 32'h2);
    rdc(`MOCH_OFS_CTRL, 32'h2, 32'h2);
    repeat ((PROC + 2) * TICK) @(posedge hclk);
    rdc(`MOCH_OFS_CTRL, 32'h2, 32'h2);
    chk(n_s, 32'h1);
    rdc(`MOCH_OFS_ZREF, 32'h0000FFFF, 32'h00000FF0);
    xfer(`MOCH_OFS_CTRL, 1'b1, 32'h4);
    repeat ((PROC + 2) * TICK) @(posedge hclk);
    rdc(`MOCH_OFS_CTRL, 32'h4, 32'h4);
    chk(n_r, 32'h1);
    rdc(`MOCH_OFS_ZREF, 32'h0000FFFF, 32'h00000FA0);
    close_out();
  end
endmodule
`default_nettype wire

// ===== verification/moch_master_model.sv
// Behavioural bus master: serial characters on the receive line and decoded request strobes.
`timescale 1ns/1ps
`default_nettype none
module moch_master_model
  import moch_pkg::*;
#(
  parameter int BIT_CYC = 868
) (
  // Clock.
  input  wire logic       hclk,
  // Serial line and decoder strobes.
  output logic            rx_pin,
  output logic            req_done,
  output logic [1:0]      req_kind,
  output logic            req_ok
);
  initial begin
    rx_pin   = 1'b1;
    req_done = 1'b0;
    req_kind = 2'h0;
    req_ok   = 1'b0;
  end
  ////////////////////////////////////////
  // One 8N1 character; the line rests high afterwards because the stop bit stays driven.
  task automatic frame(input logic [7:0] b);
    logic [9:0] bits;
    bits = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_pin <= bits[i];
      repeat (BIT_CYC) @(posedge hclk);
    end
  endtask
  // Strobe stands one cycle; released qualifiers are inverted, so they differ from the request but can still look valid.
  task automatic req(input moch_req_t k, input logic ok);
    @(posedge hclk);
    req_done <= 1'b1;
    req_kind <= k;
    req_ok   <= ok;
    @(posedge hclk);
    req_done <= 1'b0;
    req_kind <= ~k;
    req_ok   <= ~ok;
  endtask
endmodule
`default_nettype wire

// ===== verilog/moch_handler.sv
// Serial-side command and object handler with an AHB-Lite register slave.
//
// How it works
// - Bit rate inferred from observed bus pulses.
// - Red indicator double-flashes during rate detection.
// - Lock rate after good WhoIs or ReadProperty.
// - Requests may go unanswered while detecting.
// - Detection restarts on power-up and address change.
// - Identifier is vendor prefix plus station address.
// - Written identifier persists, ignores later address changes.
// - Max master and info frames apply after reinitialize.
// - Writing one to zero object starts zero.
// - Zero fails outside two percent band, clears.
// - Zero finishes within ten seconds, one means success.
// - Writing one to span object starts span.
// - Span only within five minutes after zero.
// - Span finishes within ten seconds, one means success.
// - Restore returns zero, span, area to factory.
// - Restore finishes within ten seconds, one means success.
// - Communication control needs password, supports minutes duration.
// - Reinitialize accepts cold or warm start only.
// - Reinitialize needs the configured password.
// - Fixed object set, nothing created or deleted.
// - Objects report velocity, temperature, flow, area units.
// - Six candidate rates, eight data, no parity.
// - Station addresses above 127 flagged as error.
// - New address adopted 15 seconds after last change.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "moch_cfg.svh"
module moch_handler
  import moch_pkg::*;
#(
  parameter int          TICK_CYCLES   = `MOCH_TICK_CYC,
  parameter int          VENDOR_PREFIX = 100, // Arbitrary neutral value.
  parameter logic [31:0] PASSWORD      = 32'h1234ABCD, // Arbitrary neutral value.
  parameter int          PROC_MS       = `MOCH_PROC_MS
) (
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins.
  input  wire logic        rx_pin,
  input  wire logic [7:0]  station_address_switch,
  output logic             led_red,
  // Frame decoder and measurement path.
  input  wire logic        req_done,
  input  wire logic [1:0]  req_kind,
  input  wire logic        req_ok,
  input  wire logic [15:0] velocity_now,
  output logic      [2:0]  baud_sel,
  output logic             baud_locked,
  output logic             addr_err,
  output logic      [7:0]  active_addr,
  output logic             comm_disabled,
  output logic             reinit_pulse,
  output logic             reinit_warm,
  output logic             cal_zero_pulse,
  output logic             cal_span_pulse,
  output logic             cal_restore_pulse
);

  function automatic logic [2:0] rate_of(input logic [15:0] w);
    if (w > 16'((`MOCH_BIT_CYC_0 + `MOCH_BIT_CYC_1) / 2)) rate_of = 3'h0;
    else if (w > 16'((`MOCH_BIT_CYC_1 + `MOCH_BIT_CYC_2) / 2)) rate_of = 3'h1;
    else if (w > 16'((`MOCH_BIT_CYC_2 + `MOCH_BIT_CYC_3) / 2)) rate_of = 3'h2;
    else if (w > 16'((`MOCH_BIT_CYC_3 + `MOCH_BIT_CYC_4) / 2)) rate_of = 3'h3;
    else if (w > 16'((`MOCH_BIT_CYC_4 + `MOCH_BIT_CYC_5) / 2)) rate_of = 3'h4;
    else rate_of = 3'h5;
  endfunction

  function automatic logic [7:0] obj_entry(input logic [3:0] i);
    case (i)
      4'h0:    obj_entry = {OBJ_DEVICE, 1'b0, 5'h00};
      4'h1:    obj_entry = {OBJ_AIN, 1'b0, 5'h01};
      4'h2:    obj_entry = {OBJ_AIN, 1'b1, 5'h02};
      4'h3:    obj_entry = {OBJ_AIN, 1'b0, 5'h03};
      4'h4:    obj_entry = {OBJ_AIN, 1'b1, 5'h04};
      4'h5:    obj_entry = {OBJ_AVAL, 1'b0, 5'h01};
      4'h6:    obj_entry = {OBJ_AVAL, 1'b1, 5'h02};
      4'h7:    obj_entry = {OBJ_AVAL, 1'b0, 5'h03};
      4'h8:    obj_entry = {OBJ_AVAL, 1'b1, 5'h04};
      4'h9:    obj_entry = {OBJ_BVAL, 1'b0, 5'h01};
      4'hA:    obj_entry = {OBJ_BVAL, 1'b0, 5'h02};
      4'hB:    obj_entry = {OBJ_BVAL, 1'b0, 5'h03};
      default: obj_entry = 8'h00;
    endcase
  endfunction

  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        wr_fire;
  logic        ms_tick;
  logic [16:0] tick_cnt;
  logic        rx_s1, rx_s2, rx_prev;
  logic [7:0]  sw_s1, sw_s2, sw_prev;
  logic [15:0] run_w, min_w;
  logic        addr_adopt, settle_busy;
  logic [1:0]  boot;
  logic [13:0] settle_ms;
  logic [21:0] dev_id, id_written;
  logic        id_explicit;
  logic [6:0]  mm_pend, mm_eff;
  logic [7:0]  mi_pend, mi_eff;
  logic [15:0] zref;
  logic [18:0] zwin;
  logic [31:0] pass_try;
  logic        svc_ok, svc_err;
  logic [7:0]  dcc_min;
  logic [15:0] min_ms;
  logic [3:0]  obj_idx;
  logic [10:0] led_ms;
  logic [2:0]  pv, start_req, start_ok, done_p;
  logic [21:0] band;
  logic        pass_ok, svc_wr;

  assign wr_fire  = wr_pend;
  assign svc_wr   = wr_fire && wr_addr == `MOCH_OFS_SVC;
  assign pass_ok  = pass_try == PASSWORD;
  assign band     = 22'(velocity_now > zref ? velocity_now - zref : zref - velocity_now) * 22'(`MOCH_ZERO_TOL_DIV);
  assign start_ok = {1'b1, zwin != 19'h0, band <= 22'(zref)};

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, read data captured at the address phase.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= hsel && hready && htrans[1] && hwrite;
      wr_addr   <= {haddr[7:2], 2'b00};
      if (hsel && hready && htrans[1] && !hwrite) begin
        case ({haddr[7:2], 2'b00})
          `MOCH_OFS_CTRL:   hrdata <= {29'h0, pv};
          `MOCH_OFS_STAT:   hrdata <= {12'h0, svc_err, svc_ok, comm_disabled, zwin != 19'h0, active_addr,
                                       1'b0, baud_sel, addr_err, settle_busy, id_explicit, baud_locked};
          `MOCH_OFS_DEVID:  hrdata <= {10'h0, dev_id};
          `MOCH_OFS_NETCFG: hrdata <= {mi_eff, 1'b0, mm_eff, mi_pend, 1'b0, mm_pend};
          `MOCH_OFS_ZREF:   hrdata <= {16'h0, zref};
          `MOCH_OFS_SVC:    hrdata <= {24'h0, dcc_min};
          `MOCH_OFS_OBJ:    hrdata <= {20'h0, obj_idx, obj_entry(obj_idx)};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and pin synchronisers.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 17'h0;
      ms_tick  <= 1'b0;
    end else begin
      ms_tick  <= tick_cnt == 17'(TICK_CYCLES - 1);
      tick_cnt <= tick_cnt == 17'(TICK_CYCLES - 1) ? 17'h0 : tick_cnt + 17'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      sw_s1 <= station_address_switch;
      sw_s2 <= sw_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Station address settling, range check and identifier.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot        <= 2'h0;
      sw_prev     <= 8'h00;
      settle_ms   <= 14'h0;
      settle_busy <= 1'b0;
      addr_adopt  <= 1'b0;
      active_addr <= 8'h00;
      addr_err    <= 1'b0;
    end else begin
      addr_adopt <= 1'b0;
      sw_prev    <= sw_s2;
      if (boot != 2'h3) begin
        boot <= boot + 2'h1;
        if (boot == 2'h2) begin
          addr_adopt <= 1'b1;
        end
      end else if (sw_s2 != sw_prev) begin
        settle_busy <= 1'b1;
        settle_ms   <= 14'h0;
      end else if (settle_busy && ms_tick) begin
        settle_ms <= settle_ms + 14'h1;
        if (settle_ms == 14'(`MOCH_ADDR_SETTLE_MS - 1)) begin
          settle_busy <= 1'b0;
          addr_adopt  <= 1'b1;
        end
      end
      if (addr_adopt) begin
        active_addr <= sw_prev;
        addr_err    <= sw_prev > 8'(`MOCH_ADDR_MAX);
      end
    end
  end

  // The written identifier models persistent storage; only a full reset clears it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      id_explicit <= 1'b0;
      id_written  <= 22'h0;
      dev_id      <= 22'h0;
    end else begin
      if (wr_fire && wr_addr == `MOCH_OFS_DEVID) begin
        id_explicit <= 1'b1;
        id_written  <= hwdata[21:0];
      end
      dev_id <= id_explicit ? id_written : 22'(VENDOR_PREFIX * 1000) + 22'(active_addr);
    end
  end

  // Pending values reach the live copy only at an accepted reinitialize; reset loads both copies with the defaults.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mm_pend <= `MOCH_RST_MAXMASTER;
      mi_pend <= `MOCH_RST_MAXINFO;
      mm_eff  <= `MOCH_RST_MAXMASTER;
      mi_eff  <= `MOCH_RST_MAXINFO;
    end else begin
      if (wr_fire && wr_addr == `MOCH_OFS_NETCFG) begin
        mm_pend <= hwdata[6:0];
        mi_pend <= hwdata[15:8];
      end
      if (reinit_pulse) begin
        mm_eff <= mm_pend;
        mi_eff <= mi_pend;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate detection from the shortest clean pulse seen on the line.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_prev     <= 1'b1;
      run_w       <= 16'h0;
      min_w       <= 16'hFFFF;
      baud_sel    <= 3'h0;
      baud_locked <= 1'b0;
    end else begin
      rx_prev <= rx_s2;
      run_w   <= rx_s2 != rx_prev ? 16'h1 : (run_w == 16'hFFFF ? run_w : run_w + 16'h1);
      if (addr_adopt) begin
        min_w       <= 16'hFFFF;
        baud_locked <= 1'b0;
      end else if (!baud_locked) begin
        if (rx_s2 != rx_prev && run_w >= 16'(`MOCH_GLITCH_CYC) && run_w < min_w) begin
          min_w <= run_w;
        end
        baud_sel <= rate_of(min_w);
        // Until lock the decoder may drop frames; the master keeps retrying.
        if (req_done && req_ok && min_w != 16'hFFFF && !addr_err
            && (req_kind == REQ_WHOIS || req_kind == REQ_READPROP)) begin
          baud_locked <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_ms  <= 11'h0;
      led_red <= 1'b0;
    end else begin
      if (ms_tick) begin
        led_ms <= led_ms == 11'(`MOCH_LED_PERIOD_MS - 1) ? 11'h0 : led_ms + 11'h1;
      end
      led_red <= (led_ms < 11'(`MOCH_LED_ON_MS))
              || (!addr_err && !baud_locked && led_ms >= 11'(`MOCH_LED_GAP_MS)
                  && led_ms < 11'(`MOCH_LED_GAP_MS + `MOCH_LED_ON_MS));
      if (baud_locked && !addr_err) begin
        led_red <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zero, span and restore procedures, one per command object.

  for (genvar i = 0; i < 3; i++) begin : g_proc
    moch_proc_t  st;
    logic [13:0] run_ms;
    assign start_req[i] = wr_fire && wr_addr == `MOCH_OFS_CTRL && hwdata[i] && st != P_RUN && st != P_FAIL;
    assign pv[i]        = st != P_IDLE;
    assign done_p[i]    = st == P_RUN && ms_tick && run_ms == 14'(PROC_MS - 1);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        st     <= P_IDLE;
        run_ms <= 14'h0;
      end else begin
        unique case (st)
          P_IDLE, P_DONE: begin
            if (start_req[i]) begin
              st     <= start_ok[i] ? P_RUN : P_FAIL;
              run_ms <= 14'h0;
            end else if (wr_fire && wr_addr == `MOCH_OFS_CTRL && !hwdata[i]) begin
              st <= P_IDLE;
            end
          end
          P_RUN: begin
            if (ms_tick) begin
              run_ms <= run_ms + 14'h1;
            end
            if (done_p[i]) begin
              st <= P_DONE;
            end
          end
          P_FAIL: st <= P_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zref              <= `MOCH_RST_ZREF;
      zwin              <= 19'h0;
      cal_zero_pulse    <= 1'b0;
      cal_span_pulse    <= 1'b0;
      cal_restore_pulse <= 1'b0;
    end else begin
      cal_zero_pulse    <= done_p[0];
      cal_span_pulse    <= done_p[1];
      cal_restore_pulse <= done_p[2];
      if (done_p[0]) begin
        zwin <= 19'(`MOCH_SPAN_WIN_MS);
      end else if (done_p[2]) begin
        zwin <= 19'h0;
      end else if (ms_tick && zwin != 19'h0) begin
        zwin <= zwin - 19'h1;
      end
      if (done_p[1]) begin
        zref <= velocity_now;
      end else if (done_p[2]) begin
        zref <= `MOCH_RST_ZREF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Password-gated services.

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pass_try      <= 32'h0000_0000;
      obj_idx       <= 4'h0;
      svc_ok        <= 1'b0;
      svc_err       <= 1'b0;
      comm_disabled <= 1'b0;
      dcc_min       <= 8'h00;
      min_ms        <= 16'h0;
      reinit_pulse  <= 1'b0;
      reinit_warm   <= 1'b0;
    end else begin
      reinit_pulse <= 1'b0;
      if (wr_fire && wr_addr == `MOCH_OFS_PASS) begin
        pass_try <= hwdata;
      end
      if (wr_fire && wr_addr == `MOCH_OFS_OBJ) begin
        obj_idx <= hwdata[3:0] < 4'(`MOCH_OBJ_COUNT) ? hwdata[3:0] : 4'h0;
      end
      if (comm_disabled && dcc_min != 8'h00 && ms_tick) begin
        min_ms <= min_ms == 16'(`MOCH_MINUTE_MS - 1) ? 16'h0 : min_ms + 16'h1;
        if (min_ms == 16'(`MOCH_MINUTE_MS - 1)) begin
          dcc_min <= dcc_min - 8'h01;
          if (dcc_min == 8'h01) begin
            comm_disabled <= 1'b0;
          end
        end
      end
      if (svc_wr) begin
        svc_ok  <= 1'b0;
        svc_err <= 1'b1;
        if (pass_ok && !hwdata[0] && hwdata[3:1] <= 3'h1) begin
          svc_ok        <= 1'b1;
          svc_err       <= 1'b0;
          comm_disabled <= hwdata[1];
          dcc_min       <= hwdata[1] ? hwdata[15:8] : 8'h00;
          min_ms        <= 16'h0;
        end
        if (pass_ok && hwdata[0] && hwdata[3:1] <= 3'h1) begin
          svc_ok       <= 1'b1;
          svc_err      <= 1'b0;
          reinit_pulse <= 1'b1;
          reinit_warm  <= hwdata[1];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_baud_lock_cause: assert property ($rose(baud_locked) |-> $past(req_done && req_ok))
    else $error("rate locked without a good request");
  a_addr_restart: assert property (addr_adopt |=> !baud_locked && min_w == 16'hFFFF)
    else $error("rate detection not restarted on address change");
  a_led_double: assert property (!baud_locked && !addr_err && ms_tick
                                 && led_ms == 11'(`MOCH_LED_GAP_MS - 1) |-> ##2 led_red)
    else $error("second flash missing during detection");
  a_devid_derive: assert property (addr_adopt && !id_explicit ##1 !id_explicit
                                   |=> dev_id == 22'(VENDOR_PREFIX * 1000) + 22'(active_addr))
    else $error("identifier does not follow address");
  a_devid_keep: assert property (id_explicit && !(wr_fire && wr_addr == `MOCH_OFS_DEVID)
                                 ##1 !(wr_fire && wr_addr == `MOCH_OFS_DEVID) |=> $stable(dev_id))
    else $error("written identifier changed");
  a_netcfg_hold: assert property (!reinit_pulse |=> $stable(mm_eff) && $stable(mi_eff))
    else $error("network settings applied early");
  a_zero_band: assert property (start_req[0] && band > 22'(zref) |=> ##1 !pv[0])
    else $error("zero outside band not failed");
  a_span_gate: assert property (start_req[1] && zwin == 19'h0 |=> pv[1] ##1 !pv[1])
    else $error("span accepted without recent zero");
  a_proc_bound: assert property (g_proc[0].run_ms < 14'(`MOCH_PROC_MAX_MS)
                                 && g_proc[1].run_ms < 14'(`MOCH_PROC_MAX_MS)
                                 && g_proc[2].run_ms < 14'(`MOCH_PROC_MAX_MS))
    else $error("procedure ran too long");
  a_proc_hold: assert property (pv[2] && g_proc[2].st == P_RUN |=> pv[2])
    else $error("restore object dropped while running");
  a_reinit_pw: assert property (reinit_pulse |-> $past(pass_ok && svc_wr))
    else $error("reinitialize without password");
  a_addr_range: assert property (addr_adopt && sw_prev > 8'(`MOCH_ADDR_MAX) |=> addr_err)
    else $error("bad address not flagged");

  c_lock: cover property ($rose(baud_locked));
  c_zero_ok: cover property (cal_zero_pulse);
  c_span_ok: cover property (cal_span_pulse);
  c_reinit: cover property (reinit_pulse && reinit_warm);

endmodule
`default_nettype wire
